// *** core/irqfd_defines.svh ***
// Constants for the interrupt request format decoder
// Summary of operation
// - Address bits 31:20 equal FEEh mean interrupt
// - Own fault and completion events bypass remapping
// - Address bit 4 clear means compatibility format
// - Address bit 4 set means remappable format
// - Handle from address 19:5 plus bit 2
// - Address bit 3 is secondary index valid
// - Address bits 1:0 are ignored
// - Data 31:16 must be zero when valid
// - Data ignored when secondary index invalid
// - Data 15:0 is secondary index when valid
// - Requester identifier becomes the source identifier
// - Without remapping built only compatibility format accepted; built but inactive, remappable passes as compatibility
// - Remapping capability advertised by a bit
// - Index is handle, plus secondary when valid
// - Reserved bits set: block, reason 20h
// - Compatibility blocked, while remapping is active, under extended mode or disallowed
`ifndef IRQFD_DEFINES_SVH
`define IRQFD_DEFINES_SVH
`define IRQFD_ID_HI 31
`define IRQFD_ID_LO 20
`define IRQFD_ID_VALUE 12'hfee
`define IRQFD_FMT_BIT 4
`define IRQFD_SIV_BIT 3
`define IRQFD_H15_BIT 2
`define IRQFD_HLO_HI 19
`define IRQFD_HLO_LO 5
`define IRQFD_RSV_REASON 8'h20
`define IRQFD_BOUND_REASON 8'h21
`define IRQFD_NO_REASON 8'h00
`endif

// *** core/irqfd_pkg.sv ***
// Types for the interrupt request format decoder
package irqfd_pkg;
    typedef enum logic [1:0] {
        IRQFD_NOT_IRQ,
        IRQFD_COMPAT,
        IRQFD_REMAP
    } irqfd_class_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [31:0] data;
        logic [15:0] requester_id;
        logic internal_event;
    } irqfd_wr_t;

    typedef struct packed {
        logic valid;
        irqfd_class_t format_class;
        logic [15:0] source_id;
        logic [15:0] handle;
        logic secondary_index_valid;
        logic [15:0] secondary_index;
        logic [16:0] table_index;
        logic passthrough;
        logic blocked;
        logic [7:0] fault_reason;
        logic fault_valid;
    } irqfd_req_t;

    typedef struct packed {
        irqfd_req_t req;
        logic bypass_valid;
        irqfd_wr_t bypass;
    } irqfd_state_t;
endpackage : irqfd_pkg

// *** core/irqfd_decoder.sv ***
// Interrupt request format decoder top module
`timescale 1ns/10ps
`default_nettype none
`include "irqfd_defines.svh"
module irqfd_decoder #(
    parameter bit REMAP_CAPABLE = 1'b1
) (
    input wire logic clock,
    input wire logic srst,
    input wire irqfd_pkg::irqfd_wr_t wr_in,
    input wire logic remap_active_status,
    input wire logic extended_irq_mode_on,
    input wire logic compat_format_allowed,
    input wire logic [16:0] table_entries,
    output logic remap_capable_q,
    output irqfd_pkg::irqfd_req_t req_out_q,
    output logic bypass_valid_q,
    output irqfd_pkg::irqfd_wr_t bypass_out_q
);
    irqfd_pkg::irqfd_state_t state_q;
    irqfd_pkg::irqfd_state_t state_d;
    logic cap_q;

    // Pieces of the incoming write, decoded one step at a time
    logic in_window;
    logic own_event;
    logic is_irq;
    logic fmt_remap;
    logic siv;
    logic [15:0] handle;
    logic [15:0] sec_index;
    logic [15:0] rsv_field;
    logic rsv_bad;
    logic [16:0] idx;
    logic idx_over;
    logic remap_fault;
    logic [7:0] remap_reason;
    logic remap_path;
    logic remap_refused;
    logic compat_gate;
    logic compat_blocked;

    ////////////////////////////////////////////////////////////////////////
    // interrupt window decode
    always_comb begin
        in_window = 1'b0;
        if (wr_in.valid) begin
            if (wr_in.addr[`IRQFD_ID_HI:`IRQFD_ID_LO] == `IRQFD_ID_VALUE) begin
                in_window = 1'b1;
            end
        end
    end

    always_comb begin
        own_event = 1'b0;
        if (wr_in.valid && wr_in.internal_event) begin
            own_event = 1'b1;
        end
    end

    // Own events never enter the lookup path, even inside the window
    always_comb begin
        is_irq = 1'b0;
        if (in_window && !own_event) begin
            is_irq = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // format bit
    always_comb begin
        fmt_remap = wr_in.addr[`IRQFD_FMT_BIT];
    end

    always_comb begin
        siv = wr_in.addr[`IRQFD_SIV_BIT];
    end

    always_comb begin
        handle = 16'h0000;
        handle[15] = wr_in.addr[`IRQFD_H15_BIT];
        handle[14:0] = wr_in.addr[`IRQFD_HLO_HI:`IRQFD_HLO_LO];
    end

    always_comb begin
        sec_index = 16'h0000;
        if (siv) begin
            sec_index = wr_in.data[15:0];
        end
    end

    // Upper data half, reserved only while the flag is set
    always_comb begin
        rsv_field = wr_in.data[31:16];
    end

    always_comb begin
        rsv_bad = 1'b0;
        if (siv && (rsv_field != 16'h0000)) begin
            rsv_bad = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // table index sum
    // Seventeen bits keep the carry, so a wrapped sum cannot slip under the bound
    always_comb begin
        idx = {1'b0, handle} + {1'b0, sec_index};
    end

    always_comb begin
        idx_over = 1'b0;
        if (idx >= table_entries) begin
            idx_over = 1'b1;
        end
    end

    always_comb begin
        remap_fault = 1'b0;
        remap_reason = `IRQFD_NO_REASON;
        if (rsv_bad) begin
            remap_fault = 1'b1;
            remap_reason = `IRQFD_RSV_REASON;
        end else if (idx_over) begin
            remap_fault = 1'b1;
            remap_reason = `IRQFD_BOUND_REASON;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // remap path only when built
    // With remapping switched off every request is handled as compatibility
    always_comb begin
        remap_path = 1'b0;
        if (fmt_remap && REMAP_CAPABLE && remap_active_status) begin
            remap_path = 1'b1;
        end
    end

    always_comb begin
        remap_refused = 1'b0;
        if (fmt_remap && !REMAP_CAPABLE) begin
            remap_refused = 1'b1;
        end
    end

    always_comb begin
        compat_gate = 1'b0;
        if (!fmt_remap && REMAP_CAPABLE && remap_active_status) begin
            if (extended_irq_mode_on || !compat_format_allowed) begin
                compat_gate = 1'b1;
            end
        end
    end

    always_comb begin
        compat_blocked = remap_refused || compat_gate;
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = '0;
        if (own_event) begin
            state_d.bypass_valid = 1'b1;
            state_d.bypass = wr_in;
        end
        state_d.req.valid = is_irq;
        state_d.req.source_id = wr_in.requester_id;
        state_d.req.format_class = irqfd_pkg::IRQFD_NOT_IRQ;
        state_d.req.fault_reason = `IRQFD_NO_REASON;
        if (is_irq && !remap_path) begin
            state_d.req.format_class = irqfd_pkg::IRQFD_COMPAT;
            // Compatibility blocking raises no fault of its own
            state_d.req.blocked = compat_blocked;
            state_d.req.passthrough = !compat_blocked;
        end else if (is_irq) begin
            state_d.req.format_class = irqfd_pkg::IRQFD_REMAP;
            state_d.req.handle = handle;
            state_d.req.secondary_index_valid = siv;
            state_d.req.secondary_index = sec_index;
            state_d.req.table_index = idx;
            state_d.req.blocked = remap_fault;
            state_d.req.fault_valid = remap_fault;
            state_d.req.fault_reason = remap_reason;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Capability reads zero while reset is held
    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= '0;
            cap_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cap_q <= REMAP_CAPABLE;
        end
    end

    assign remap_capable_q = cap_q;
    assign req_out_q = state_q.req;
    assign bypass_valid_q = state_q.bypass_valid;
    assign bypass_out_q = state_q.bypass;
endmodule : irqfd_decoder
`default_nettype wire

// *** dv/irqfd_props.sv ***
// Port checker for the interrupt format decoder
`timescale 1ns/10ps
`default_nettype none
module irqfd_props (
    input wire logic clock,
    input wire logic srst,
    input wire irqfd_pkg::irqfd_wr_t wr_in,
    input wire logic remap_active_status,
    input wire irqfd_pkg::irqfd_req_t req_out_q,
    input wire logic bypass_valid_q,
    input wire logic remap_capable_q
);
    wire logic hit = wr_in.valid && wr_in.addr[31:20] == 12'hfee && !wr_in.internal_event;
    wire logic [15:0] hnd = {wr_in.addr[2], wr_in.addr[19:5]};
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    sequence s_irq; hit; endsequence
    sequence s_rm; s_irq ##0 wr_in.addr[4] && remap_active_status && remap_capable_q; endsequence
    a_irq_strobe: assert property (s_irq |=> req_out_q.valid)
        else $error("no strobe");
    a_no_stray: assert property (!hit |=> !req_out_q.valid)
        else $error("stray strobe");
    a_own_bypass: assert property (wr_in.valid && wr_in.internal_event |=> bypass_valid_q)
        else $error("no bypass");
    a_compat_class: assert property (s_irq ##0 !wr_in.addr[4] |=> req_out_q.format_class == 1)
        else $error("bad compat class");
    a_remap_class: assert property (s_rm |=> req_out_q.format_class == 2)
        else $error("bad remap class");
    a_handle_bits: assert property (s_rm |=> req_out_q.handle == $past(hnd))
        else $error("bad handle");
    a_siv_flag: assert property (s_rm ##0 wr_in.addr[3] |=> req_out_q.secondary_index_valid)
        else $error("bad flag");
    a_rsv_fault: assert property (s_rm ##0 wr_in.addr[3] && wr_in.data[31:16] != 0 |=>
        req_out_q.blocked && req_out_q.fault_reason == 8'h20) else $error("no fault");
endmodule : irqfd_props
`default_nettype wire

// *** dv/irqfd_source.sv ***
// Random interrupt write source
`timescale 1ns/10ps
`default_nettype none
module irqfd_source (
    input wire logic clock,
    output irqfd_pkg::irqfd_wr_t wr_out
);
    integer seed = 32'hd292_f582;
    initial wr_out = '0;
    always @(posedge clock) begin
        wr_out.valid <= $random(seed) % 4 != 0;
        wr_out.addr <= seed[0] ? {12'hfee, 20'($random(seed))} : $random(seed);
        wr_out.data <= seed[1] ? $random(seed) & 32'h0000_ffff : $random(seed);
        wr_out.requester_id <= 16'($random(seed));
        wr_out.internal_event <= $random(seed) % 8 == 0;
    end
endmodule : irqfd_source
`default_nettype wire

// *** dv/testbench.sv ***
// Bench for the interrupt format decoder
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clock = 0, srst = 1, ras = 0, eim = 0, cfa = 0, cap, bv, irq, rm, rsv, blk, cap0;
    logic [16:0] te = '0, idx;
    logic [15:0] hd;
    logic [81:0] e, q[$];
    irqfd_pkg::irqfd_wr_t wr, byp, qw[$];
    irqfd_pkg::irqfd_req_t r, r0;
    integer n_errors = 0, cmp_count = 0, cyc = 0, seed = 32'hd292_f582;
    irqfd_source src (.clock(clock), .wr_out(wr));
    irqfd_decoder dut (.clock(clock), .srst(srst), .wr_in(wr), .remap_active_status(ras),
        .extended_irq_mode_on(eim), .compat_format_allowed(cfa), .table_entries(te),
        .remap_capable_q(cap), .req_out_q(r), .bypass_valid_q(bv), .bypass_out_q(byp));
    // Build without remapping, same stimulus
    irqfd_decoder #(.REMAP_CAPABLE(1'b0)) dut0 (.clock(clock), .srst(srst), .wr_in(wr),
        .remap_active_status(ras), .extended_irq_mode_on(eim), .compat_format_allowed(cfa),
        .table_entries(te), .remap_capable_q(cap0), .req_out_q(r0), .bypass_valid_q(),
        .bypass_out_q());
    initial forever #12.5 clock = ~clock;
    task chk(input logic [81:0] g, input logic [81:0] x);
        cmp_count++;
        if (g !== x) begin
            n_errors++;
            $display("Error %0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    task close_out;
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        {ras, eim, cfa} <= 3'($random(seed));
        te <= {1'b0, 16'($random(seed))};
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_errors++;
            close_out;
        end
    end
    // Model sees pre-edge inputs; results are compared at the falling edge once settled
    always @(posedge clock) begin
        hd = {wr.addr[2], wr.addr[19:5]};
        idx = hd + (wr.addr[3] ? wr.data[15:0] : 16'h0000);
        irq = wr.valid && wr.addr[31:20] == 12'hfee && !wr.internal_event && !srst;
        rm = wr.addr[4] && ras;
        rsv = wr.addr[3] && wr.data[31:16] != 16'h0000;
        blk = rm ? rsv || idx >= te : ras && (eim || !cfa);
        q.push_back({!rm && !blk, rm && blk, irq, wr.valid && wr.internal_event && !srst,
            irq && rm, rm ? 2'd2 : 2'd1, wr.requester_id, blk,
            rm ? (rsv ? 8'h20 : blk ? 8'h21 : 8'h00) : 8'h00,
            wr.addr[3], wr.addr[3] ? wr.data[15:0] : 16'h0000, idx, hd});
        qw.push_back(wr);
    end
    always @(negedge clock) if (q.size() != 0) begin
        e = q.pop_front();
        chk({r.valid, bv}, e[79:78]);
        if (e[79]) chk({r.format_class, r.source_id, r.blocked, r.fault_reason}, e[76:50]);
        if (e[77]) chk({r.secondary_index_valid, r.secondary_index, r.table_index, r.handle},
            e[49:0]);
        if (e[78]) chk(byp, qw[0]);
        if (e[79]) chk({r.passthrough, r.fault_valid}, e[81:80]);
        chk({r0.valid, r0.format_class, r0.blocked, r0.passthrough, r0.fault_valid},
            {e[79], e[79] ? {2'd1, qw[0].addr[4], !qw[0].addr[4]} : 4'h0, 1'b0});
        void'(qw.pop_front());
    end
    initial begin
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        repeat (3000) @(posedge clock);
        @(negedge clock);
        chk(cap, 82'h1);
        chk(cap0, 82'h0);
        close_out;
    end
endmodule : testbench
bind irqfd_decoder irqfd_props u_props (.clock(clock), .srst(srst), .wr_in(wr_in),
    .remap_active_status(remap_active_status), .req_out_q(req_out_q),
    .bypass_valid_q(bypass_valid_q), .remap_capable_q(remap_capable_q));
`default_nettype wire
